// file: src/fault_log_pkg.sv
package fault_log_pkg;

	// ****************************************
	// Instruction codes and key
	// ****************************************
	localparam logic [7:0] CMD_ERASE = 8'h71;
	localparam logic [7:0] CMD_READ_HOLDING = 8'h73;
	localparam logic [7:0] CMD_UNLOCK = 8'h74;
	localparam logic [7:0] CMD_READ_RECORD = 8'h75;
	localparam logic [7:0] CMD_READ_ALL = 8'h76;
	localparam logic [7:0] UNLOCK_KEY = 8'hac;

	// ****************************************
	// Storage geometry
	// ****************************************
	localparam int NUM_RECORDS = 16;
	localparam int RECORD_BYTES = 7;
	localparam int RECORD_BITS = 56;
	localparam logic [3:0] LAST_ROW = 4'hf;
	localparam logic [2:0] LAST_BYTE = 3'h6;

	// ****************************************
	// Record selection byte and status byte layout
	// ****************************************
	localparam int SEL_ROW_LSB = 4;
	localparam int STATUS_REQ_LSB = 6;
	localparam int STATUS_EN_LSB = 4;
	localparam logic [1:0] FIELD_ZERO = 2'h0;
	localparam logic [1:0] FIELD_ONES = 2'h3;
	localparam logic [3:0] STATUS_LOW_BITS = 4'h0;
	localparam logic [7:0] STATUS_RESET = 8'h00;

	// ****************************************
	// Access states and read modes
	// ****************************************
	typedef enum logic [1:0] {
		ACC_RECORDING = 2'b00,
		ACC_REQUESTED = 2'b01,
		ACC_GRANTED = 2'b10
	} access_type;

	typedef enum logic [1:0] {
		RD_STATUS = 2'b00,
		RD_HOLDING = 2'b01,
		RD_RECORDS = 2'b10
	} read_mode_type;

endpackage

// file: src/byte_stream_if.sv
`timescale 1ns/100ps
interface byte_stream_if;
	logic valid;
	logic ready;
	logic [7:0] data;
	logic flush;

	modport source (
		output valid,
		output data,
		output flush,
		input ready
	);

	modport sink (
		input valid,
		input data,
		input flush,
		output ready
	);
endinterface

// file: src/two_entry_buffer.sv
`timescale 1ns/100ps
module two_entry_buffer (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// Filling side
	byte_stream_if.sink fill,
	// Draining side
	output logic out_valid,
	output logic [7:0] out_data,
	input wire logic out_ready
);
	logic [7:0] slot [0:1];
	logic wr_ptr;
	logic rd_ptr;
	logic [1:0] count;
	logic push;
	logic pop;

	assign fill.ready = (count != 2'd2);
	assign out_valid = (count != 2'd0);
	assign out_data = slot[rd_ptr];
	assign push = fill.valid && fill.ready;
	assign pop = out_valid && out_ready;

	always_ff @(posedge clk_sys) begin
		if (push) begin
			slot[wr_ptr] <= fill.data;
		end
	end

	// A flush drops prefetched bytes so a new read starts clean.
	always_ff @(posedge clk_sys) begin
		if (sys_rst || fill.flush) begin
			wr_ptr <= 1'b0;
			rd_ptr <= 1'b0;
			count <= 2'd0;
		end else begin
			if (push) begin
				wr_ptr <= ~wr_ptr;
			end
			if (pop) begin
				rd_ptr <= ~rd_ptr;
			end
			count <= count + {1'b0, push} - {1'b0, pop};
		end
	end
endmodule

// file: src/fault_log_access.sv
`timescale 1ns/100ps
module fault_log_access (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// Transaction events from the serial slave front end
	input wire logic wr_start,
	input wire logic wr_valid,
	input wire logic [7:0] wr_data,
	input wire logic rd_start,
	input wire logic bus_stop,
	// Read data towards the front end
	output logic rd_valid,
	output logic [7:0] rd_data,
	input wire logic rd_ready,
	// Device state
	input wire logic safe_state,
	input wire logic prog_mode,
	input wire logic eeprom_busy,
	// Fault recorder
	input wire logic rec_we,
	input wire logic [3:0] rec_row,
	input wire logic [55:0] holding_reg,
	output logic recording_enabled,
	// Reconfiguration request
	input wire logic reconfig_req,
	output logic reconfig_reject,
	// Status
	output logic [7:0] fault_log_access_state,
	output logic erasing
);

	// ****************************************
	// Storage
	// ****************************************
	logic [55:0] store [0:fault_log_pkg::NUM_RECORDS-1];
	logic [3:0] erase_row;
	logic erase_start;
	logic rec_accept;

	fault_log_pkg::access_type access;
	logic [7:0] instr;
	logic [7:0] sel;
	logic [1:0] wr_count;
	logic rec_busy;

	// Recording owns the store only while access is still ACC_RECORDING and no erase runs.
	assign rec_accept = rec_we && (access == fault_log_pkg::ACC_RECORDING) && !erasing;
	assign recording_enabled = (access == fault_log_pkg::ACC_RECORDING);

	// A record write in flight is the recorder's, so it is seen for two cycles: its accept cycle and the one after.
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			rec_busy <= 1'b0;
		end else begin
			rec_busy <= rec_accept;
		end
	end

	assign reconfig_reject = reconfig_req && (rec_busy || rec_accept);

	// The erase stands at the STOP of a write holding only its instruction.
	assign erase_start = bus_stop && (wr_count == 2'd1) && (instr == fault_log_pkg::CMD_ERASE)
		&& prog_mode && (access == fault_log_pkg::ACC_GRANTED) && !erasing;

	// One row is cleared per cycle; the store is hidden from readers meanwhile.
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			erasing <= 1'b0;
			erase_row <= 4'h0;
		end else if (erase_start) begin
			erasing <= 1'b1;
			erase_row <= 4'h0;
		end else if (erasing) begin
			erase_row <= erase_row + 4'h1;
			if (erase_row == fault_log_pkg::LAST_ROW) begin
				erasing <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (erasing) begin
			store[erase_row] <= '0;
		end else if (rec_accept) begin
			store[rec_row] <= holding_reg;
		end
	end

	// ****************************************
	// Write phase decode
	// ****************************************
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			wr_count <= 2'd0;
			instr <= 8'h00;
			sel <= 8'h00;
		end else if (wr_start) begin
			wr_count <= 2'd0;
		end else if (wr_valid) begin
			if (wr_count == 2'd0) begin
				instr <= wr_data;
			end else if (wr_count == 2'd1) begin
				sel <= wr_data;
			end
			if (wr_count != 2'd3) begin
				wr_count <= wr_count + 2'd1;
			end
		end
	end

	// ****************************************
	// Access handshake
	// ****************************************
	logic key_byte;
	assign key_byte = wr_valid && !wr_start && (wr_count == 2'd1)
		&& (instr == fault_log_pkg::CMD_UNLOCK);

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			access <= fault_log_pkg::ACC_RECORDING;
		end else if (key_byte) begin
			if (wr_data == fault_log_pkg::UNLOCK_KEY) begin
				access <= fault_log_pkg::ACC_REQUESTED;
			end else begin
				access <= fault_log_pkg::ACC_RECORDING;
			end
		end else begin
			case (access)
				fault_log_pkg::ACC_REQUESTED: begin
					// The log's own erase is an on-chip erase too, so it holds the grant back.
					if (!rec_busy && !eeprom_busy && !erasing) begin
						access <= fault_log_pkg::ACC_GRANTED;
					end
				end
				fault_log_pkg::ACC_RECORDING: access <= fault_log_pkg::ACC_RECORDING;
				fault_log_pkg::ACC_GRANTED: access <= fault_log_pkg::ACC_GRANTED;
				default: access <= fault_log_pkg::ACC_RECORDING;
			endcase
		end
	end

	logic [1:0] req_bits;
	logic [1:0] en_bits;

	always_comb begin
		req_bits = fault_log_pkg::FIELD_ZERO;
		en_bits = fault_log_pkg::FIELD_ZERO;
		case (access)
			fault_log_pkg::ACC_RECORDING: en_bits = fault_log_pkg::FIELD_ONES;
			fault_log_pkg::ACC_REQUESTED: req_bits = fault_log_pkg::FIELD_ONES;
			fault_log_pkg::ACC_GRANTED: begin
				req_bits = fault_log_pkg::FIELD_ONES;
				en_bits = fault_log_pkg::FIELD_ONES;
			end
			default: req_bits = fault_log_pkg::FIELD_ZERO;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			fault_log_access_state <= fault_log_pkg::STATUS_RESET;
		end else if (safe_state || erasing || erase_start) begin
			fault_log_access_state <= fault_log_pkg::STATUS_RESET;
		end else begin
			fault_log_access_state <= {req_bits, en_bits, fault_log_pkg::STATUS_LOW_BITS};
		end
	end

	// ****************************************
	// Read phase byte producer
	// ****************************************
	byte_stream_if stream ();

	fault_log_pkg::read_mode_type rd_mode;
	logic rd_active;
	logic [3:0] row;
	logic [2:0] byte_idx;
	logic granted;
	logic push;
	logic [55:0] word;

	assign granted = (access == fault_log_pkg::ACC_GRANTED) && !erasing;
	assign push = rd_active && stream.ready && !bus_stop;
	assign word = (rd_mode == fault_log_pkg::RD_HOLDING) ? holding_reg : store[row];

	always_ff @(posedge clk_sys) begin
		if (sys_rst || bus_stop) begin
			rd_active <= 1'b0;
			rd_mode <= fault_log_pkg::RD_STATUS;
			row <= 4'h0;
			byte_idx <= 3'h0;
		end else if (rd_start) begin
			byte_idx <= 3'h0;
			rd_active <= 1'b0;
			case (instr)
				fault_log_pkg::CMD_UNLOCK: begin
					rd_mode <= fault_log_pkg::RD_STATUS;
					rd_active <= 1'b1;
				end
				fault_log_pkg::CMD_READ_HOLDING: begin
					rd_mode <= fault_log_pkg::RD_HOLDING;
					rd_active <= granted;
				end
				fault_log_pkg::CMD_READ_RECORD: begin
					rd_mode <= fault_log_pkg::RD_RECORDS;
					row <= sel[fault_log_pkg::SEL_ROW_LSB +: 4];
					rd_active <= granted;
				end
				fault_log_pkg::CMD_READ_ALL: begin
					rd_mode <= fault_log_pkg::RD_RECORDS;
					row <= 4'h0;
					rd_active <= granted;
				end
				default: rd_active <= 1'b0;
			endcase
		end else if (push) begin
			case (rd_mode)
				fault_log_pkg::RD_STATUS: rd_active <= 1'b0;
				fault_log_pkg::RD_HOLDING: begin
					byte_idx <= byte_idx + 3'h1;
					if (byte_idx == fault_log_pkg::LAST_BYTE) begin
						rd_active <= 1'b0;
					end
				end
				fault_log_pkg::RD_RECORDS: begin
					if (byte_idx == fault_log_pkg::LAST_BYTE) begin
						byte_idx <= 3'h0;
						row <= row + 4'h1;
					end else begin
						byte_idx <= byte_idx + 3'h1;
					end
				end
				default: rd_active <= 1'b0;
			endcase
		end
	end

	// Bytes are produced ahead of the master, so the buffer must be flushed at
	// each new read or STOP; otherwise stale prefetched bytes would leak out.
	assign stream.valid = push;
	assign stream.flush = bus_stop || rd_start;
	assign stream.data = (rd_mode == fault_log_pkg::RD_STATUS) ? fault_log_access_state
		: word[{byte_idx, 3'b000} +: 8];

	two_entry_buffer out_buffer (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.fill(stream.sink),
		.out_valid(rd_valid),
		.out_data(rd_data),
		.out_ready(rd_ready)
	);

	// ****************************************
	// Checks
	// ****************************************
	property p_status_zero;
		@(posedge clk_sys) disable iff (sys_rst)
		(safe_state || erasing) |=> fault_log_access_state == 8'h00;
	endproperty
	a_status_zero: assert property (p_status_zero) else $error("status not zero");

	property p_erase_guard;
		@(posedge clk_sys) disable iff (sys_rst)
		bus_stop && !erasing && !(prog_mode && access == fault_log_pkg::ACC_GRANTED) |=> !erasing;
	endproperty
	a_erase_guard: assert property (p_erase_guard) else $error("erase without permission");

	property p_erase_span;
		@(posedge clk_sys) disable iff (sys_rst)
		erase_start |=> erasing[*8] ##9 !erasing;
	endproperty
	a_erase_span: assert property (p_erase_span) else $error("erase span wrong");

	property p_grant_wait;
		@(posedge clk_sys) disable iff (sys_rst)
		(access == fault_log_pkg::ACC_REQUESTED) && !key_byte && (rec_busy || eeprom_busy || erasing)
			|=> access == fault_log_pkg::ACC_REQUESTED;
	endproperty
	a_grant_wait: assert property (p_grant_wait) else $error("granted too early");

	property p_bad_key;
		@(posedge clk_sys) disable iff (sys_rst)
		key_byte && (wr_data != fault_log_pkg::UNLOCK_KEY) |=> recording_enabled ##1
			(fault_log_access_state == 8'h30 || $past(erasing) || $past(safe_state));
	endproperty
	a_bad_key: assert property (p_bad_key) else $error("wrong key kept access");

	property p_ignore_read;
		@(posedge clk_sys) disable iff (sys_rst)
		rd_start && !bus_stop && !granted && (instr == fault_log_pkg::CMD_READ_RECORD
			|| instr == fault_log_pkg::CMD_READ_ALL) |=> !rd_active;
	endproperty
	a_ignore_read: assert property (p_ignore_read) else $error("locked read served");

	property p_read_all_origin;
		@(posedge clk_sys) disable iff (sys_rst)
		rd_start && !bus_stop && granted && (instr == fault_log_pkg::CMD_READ_ALL)
			|=> rd_active && row == 4'h0 && byte_idx == 3'h0;
	endproperty
	a_read_all_origin: assert property (p_read_all_origin) else $error("read-all origin");

	property p_row_advance;
		@(posedge clk_sys) disable iff (sys_rst)
		push && !rd_start && (rd_mode == fault_log_pkg::RD_RECORDS) && (byte_idx == 3'h6)
			|=> byte_idx == 3'h0 && row == $past(row) + 4'h1;
	endproperty
	a_row_advance: assert property (p_row_advance) else $error("row not advanced");

	property p_stop_ends;
		@(posedge clk_sys) disable iff (sys_rst)
		bus_stop |=> !rd_active ##1 !rd_valid;
	endproperty
	a_stop_ends: assert property (p_stop_ends) else $error("read outlived stop");

	property p_reconfig;
		@(posedge clk_sys) disable iff (sys_rst)
		rec_we && recording_enabled && !erasing |-> (reconfig_reject == reconfig_req) ##1
			(!reconfig_req || reconfig_reject);
	endproperty
	a_reconfig: assert property (p_reconfig) else $error("reconfig not refused");

endmodule

// file: dv/bus_master_model.sv
`timescale 1ns/100ps
module bus_master_model (
	// Clock
	input wire logic clk_sys,
	// Transaction events
	output logic wr_start,
	output logic wr_valid,
	output logic [7:0] wr_data,
	output logic rd_start,
	output logic bus_stop,
	// Read data
	input wire logic rd_valid,
	input wire logic [7:0] rd_data,
	output logic rd_ready
);
	initial begin
		wr_start = 1'b0;
		wr_valid = 1'b0;
		wr_data = 8'h00;
		rd_start = 1'b0;
		bus_stop = 1'b0;
		rd_ready = 1'b0;
	end

	// ****************************************
	// Write phase
	// ****************************************
	// The caller unlocks before erase or reads, except the locked read-all in scen_relock, and keeps selection low bits zero.
	task automatic write_phase(input logic [7:0] ins, input logic [7:0] arg, input bit two,
		input bit stop);
		@(negedge clk_sys);
		wr_start = 1'b1;
		@(negedge clk_sys);
		wr_start = 1'b0;
		wr_valid = 1'b1;
		wr_data = ins;
		if (two) begin
			@(negedge clk_sys);
			wr_data = arg;
		end
		@(negedge clk_sys);
		wr_valid = 1'b0;
		// A released data line must not keep showing the last byte.
		wr_data = ~wr_data;
		bus_stop = stop;
		@(negedge clk_sys);
		bus_stop = 1'b0;
	endtask

	// ****************************************
	// Read phase
	// ****************************************
	// A slow reader withholds ready every other cycle, so the buffer must hold its word.
	task automatic read_phase(input int n, input bit slow, output logic [7:0] got[$]);
		int waits;
		got = {};
		waits = 0;
		@(negedge clk_sys);
		rd_start = 1'b1;
		@(negedge clk_sys);
		rd_start = 1'b0;
		while (got.size() < n && waits < 4 * n + 8) begin
			rd_ready = !slow || !rd_ready;
			@(posedge clk_sys);
			if (rd_valid && rd_ready) begin
				got.push_back(rd_data);
			end
			waits++;
			@(negedge clk_sys);
		end
		rd_ready = 1'b0;
		bus_stop = 1'b1;
		@(negedge clk_sys);
		bus_stop = 1'b0;
	endtask
endmodule

// file: dv/fault_log_access_test.sv
`timescale 1ns/100ps
module fault_log_access_test;
	logic clk_sys, sys_rst, wr_start, wr_valid, rd_start, bus_stop, rd_valid, rd_ready;
	logic [7:0] wr_data, rd_data, fault_log_access_state;
	logic safe_state, prog_mode, eeprom_busy, rec_we, recording_enabled;
	logic reconfig_req, reconfig_reject, erasing;
	logic [3:0] rec_row;
	logic [55:0] holding_reg;
	logic [55:0] exp_store [16];
	logic [7:0] got[$];
	int fails, n_tests;

	fault_log_access uut (.clk_sys(clk_sys), .sys_rst(sys_rst), .wr_start(wr_start),
		.wr_valid(wr_valid), .wr_data(wr_data), .rd_start(rd_start), .bus_stop(bus_stop),
		.rd_valid(rd_valid), .rd_data(rd_data), .rd_ready(rd_ready), .safe_state(safe_state),
		.prog_mode(prog_mode), .eeprom_busy(eeprom_busy), .rec_we(rec_we), .rec_row(rec_row),
		.holding_reg(holding_reg), .recording_enabled(recording_enabled),
		.reconfig_req(reconfig_req), .reconfig_reject(reconfig_reject),
		.fault_log_access_state(fault_log_access_state), .erasing(erasing));

	bus_master_model master (.clk_sys(clk_sys), .wr_start(wr_start), .wr_valid(wr_valid),
		.wr_data(wr_data), .rd_start(rd_start), .bus_stop(bus_stop), .rd_valid(rd_valid),
		.rd_data(rd_data), .rd_ready(rd_ready));

	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end

	// ****************************************
	// Helpers
	// ****************************************
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fails++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic tally_and_finish();
		$display("Checks %0d, mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	function automatic logic [55:0] pat(input logic [3:0] r, input logic [7:0] seed);
		for (int k = 0; k < 7; k++) begin
			pat[8 * k +: 8] = {r, 4'(k)} ^ seed;
		end
	endfunction

	task automatic record_write(input logic [3:0] row, input logic [55:0] val, input bit take);
		@(negedge clk_sys);
		rec_we = 1'b1;
		rec_row = row;
		holding_reg = val;
		#1 check("reconfig_reject", {7'h00, reconfig_reject}, {7'h00, take && reconfig_req});
		@(negedge clk_sys);
		rec_we = 1'b0;
		if (take) begin
			exp_store[row] = val;
		end
	endtask

	task automatic check_stream(input logic [3:0] row, input int n);
		check("byte count", 8'(got.size()), 8'(n));
		for (int i = 0; i < got.size() && i < n; i++) begin
			check("read byte", got[i], exp_store[4'(row + i / 7)][8 * (i % 7) +: 8]);
		end
	endtask

	task automatic read_all(input bit slow);
		master.write_phase(8'h76, 8'h00, 1'b0, 1'b0);
		master.read_phase(112, slow, got);
		check_stream(4'h0, 112);
	endtask

	task automatic unlock();
		master.write_phase(8'h74, 8'hac, 1'b1, 1'b0);
		master.read_phase(1, 1'b0, got);
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic scen_fill();
		check("idle status", fault_log_access_state, 8'h30);
		for (int r = 0; r < 16; r++) begin
			reconfig_req = 1'(r % 2);
			record_write(4'(r), pat(4'(r), 8'ha5), 1'b1);
		end
		reconfig_req = 1'b1;
	endtask

	task automatic scen_unlock_busy();
		eeprom_busy = 1'b1;
		unlock();
		check("requested status", got[0], 8'hc0);
		check("recording off", {7'h00, recording_enabled}, 8'h00);
		record_write(4'h0, pat(4'h0, 8'hff), 1'b0);
		eeprom_busy = 1'b0;
		repeat (3) @(negedge clk_sys);
		check("granted status", fault_log_access_state, 8'hf0);
	endtask

	task automatic scen_holding();
		holding_reg = 56'h66554433221100;
		master.write_phase(8'h73, 8'h00, 1'b0, 1'b0);
		master.read_phase(8, 1'b1, got);
		check("holding count", 8'(got.size()), 8'h07);
		for (int k = 0; k < 7; k++) begin
			check("holding byte", got[k], {4'(k), 4'(k)});
		end
	endtask

	task automatic scen_record();
		master.write_phase(8'h75, 8'he0, 1'b1, 1'b0);
		master.read_phase(9, 1'b1, got);
		check_stream(4'he, 9);
		read_all(1'b0);
	endtask

	task automatic scen_erase();
		int n;
		master.write_phase(8'h71, 8'h00, 1'b0, 1'b1);
		check("erase refused", {7'h00, erasing}, 8'h00);
		read_all(1'b0);
		prog_mode = 1'b1;
		master.write_phase(8'h71, 8'h00, 1'b0, 1'b1);
		check("erase status", fault_log_access_state, 8'h00);
		n = 0;
		while (erasing === 1'b1 && n < 40) begin
			n++;
			@(negedge clk_sys);
		end
		if (n >= 40) begin
			fails++;
			tally_and_finish();
		end
		check("erase length", 8'(n), 8'h10);
		prog_mode = 1'b0;
		for (int r = 0; r < 16; r++) begin
			exp_store[r] = 56'h0;
		end
		read_all(1'b1);
	endtask

	task automatic scen_relock();
		master.write_phase(8'h74, 8'h55, 1'b1, 1'b1);
		repeat (3) @(negedge clk_sys);
		check("relocked status", fault_log_access_state, 8'h30);
		check("recording on", {7'h00, recording_enabled}, 8'h01);
		record_write(4'h3, pat(4'h3, 8'h3c), 1'b1);
		master.write_phase(8'h76, 8'h00, 1'b0, 1'b0);
		master.read_phase(1, 1'b0, got);
		check("locked read", 8'(got.size()), 8'h00);
		unlock();
		repeat (3) @(negedge clk_sys);
		master.write_phase(8'h75, 8'h30, 1'b1, 1'b0);
		master.read_phase(7, 1'b0, got);
		check_stream(4'h3, 7);
	endtask

	task automatic scen_safe();
		safe_state = 1'b1;
		repeat (2) @(negedge clk_sys);
		check("safe status", fault_log_access_state, 8'h00);
		safe_state = 1'b0;
	endtask

	// A reset in mid-run must drop a granted access back to recording.
	task automatic scen_reset();
		sys_rst = 1'b1;
		repeat (2) @(negedge clk_sys);
		sys_rst = 1'b0;
		@(negedge clk_sys);
		check("reset status", fault_log_access_state, 8'h30);
		check("reset recording", {7'h00, recording_enabled}, 8'h01);
		check("reset read valid", {7'h00, rd_valid}, 8'h00);
		check("reset erasing", {7'h00, erasing}, 8'h00);
	endtask

	initial begin
		fails = 0;
		n_tests = 0;
		sys_rst = 1'b1;
		safe_state = 1'b0;
		prog_mode = 1'b0;
		eeprom_busy = 1'b0;
		rec_we = 1'b0;
		rec_row = 4'h0;
		holding_reg = 56'h0;
		reconfig_req = 1'b1;
		repeat (4) @(posedge clk_sys);
		@(negedge clk_sys);
		sys_rst = 1'b0;
		repeat (3) @(negedge clk_sys);
		scen_fill();
		scen_unlock_busy();
		scen_holding();
		scen_record();
		scen_erase();
		scen_relock();
		scen_safe();
		scen_reset();
		tally_and_finish();
	end
endmodule
